// file: dv/sblt_asserts.sv
// Port checker of the scaled blit engine
`timescale 1ns/1ps
`default_nettype none
module sblt_asserts import sblt_pkg::*; (
   input wire logic        clk,
   input wire logic        rst,
   input wire logic [7:0]  reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [31:0] reg_rdata,
   input wire logic        mem_req,
   input wire sblt_mreq_t  mem_cmd,
   input wire logic        mem_ack,
   input wire logic [7:0]  mem_rdata,
   input wire logic        busy
);
   logic [31:0] cadr_r;
   logic [3:0]  bool_r;
   logic [1:0]  rd_r;
   logic        ph_r;
   wire         bit_rd = mem_req && mem_ack && mem_cmd.bitmode && !mem_cmd.we;
   always_ff @(posedge clk) begin
      if (rst) begin
         cadr_r <= 32'h0;
         bool_r <= 4'hA;
      end else if (reg_wr && reg_addr == SBLT_REG_CMD_ADDR) begin
         cadr_r <= reg_wdata;
      end else if (reg_wr && reg_addr == SBLT_REG_BOOL) begin
         bool_r <= reg_wdata[3:0];
      end
   end
   always_ff @(posedge clk) begin
      if (rst || !busy) begin
         ph_r <= 1'b0;
         rd_r <= 2'h0;
      end else if (bit_rd) begin
         ph_r <= !ph_r;
         rd_r <= {rd_r[0], mem_rdata[0]};
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   sequence s_dst_rd; mem_req && mem_cmd.bitmode && !mem_cmd.we; endsequence
   sequence s_pix_wr; mem_req && mem_cmd.bitmode && mem_cmd.we; endsequence
   property p_rd_zero; !$past(reg_rd) |-> reg_rdata == 32'h0; endproperty
   property p_req_hold; mem_req && !mem_ack |=> mem_req && $stable(mem_cmd); endproperty
   property p_idle; !busy |-> !mem_req; endproperty
   property p_fetch;
      $rose(busy) |-> ##[0:2] (mem_req && !mem_cmd.bitmode && mem_cmd.addr == cadr_r);
   endproperty
   property p_dst_next; bit_rd && !ph_r |=> s_dst_rd; endproperty
   property p_wr_addr;
      bit_rd && ph_r |=> s_pix_wr ##0 mem_cmd.addr == $past(mem_cmd.addr);
   endproperty
   property p_wr_val; s_pix_wr |-> mem_cmd.wdata[0] == bool_r[rd_r]; endproperty
   property p_wr_gap; s_pix_wr ##0 mem_ack |=> !mem_req; endproperty
   property p_bwb;
      mem_req && mem_cmd.we && !mem_cmd.bitmode |-> (mem_cmd.addr - cadr_r) inside {[1:17]};
   endproperty
   a_rd_zero: assert property (p_rd_zero) else $error("read data not zero");
   a_req_hold: assert property (p_req_hold) else $error("request dropped");
   a_idle: assert property (p_idle) else $error("request while idle");
   a_fetch: assert property (p_fetch) else $error("first fetch wrong");
   a_dst_next: assert property (p_dst_next) else $error("no dest read");
   a_wr_addr: assert property (p_wr_addr) else $error("write address");
   a_wr_val: assert property (p_wr_val) else $error("pixel value");
   a_wr_gap: assert property (p_wr_gap) else $error("no gap after write");
   a_bwb: assert property (p_bwb) else $error("writeback address");
endmodule : sblt_asserts
bind sblt_engine sblt_asserts u_chk (.clk(clk), .rst(rst), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .mem_req(mem_req), .mem_cmd(mem_cmd), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .busy(busy));
`default_nettype wire

// file: dv/sblt_mem_model.sv
// Command and bitmap memory model
`timescale 1ns/1ps
`default_nettype none
module sblt_mem_model import sblt_pkg::*; (
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic [1:0] dly,
   input  wire logic       mem_req,
   input  wire sblt_mreq_t mem_cmd,
   output logic            mem_ack,
   output logic      [7:0] mem_rdata
);
   logic [7:0]  cmd [0:255];
   logic [31:0] wa_q [$];
   logic        wd_q [$];
   int          n_bwr;
   logic [1:0]  cnt;
   function automatic logic pat(input logic [31:0] a);
      return a[0] ^ a[2] ^ a[5] ^ a[9];
   endfunction : pat
   always @(posedge clk) begin
      if (rst || !mem_req || mem_ack) begin
         mem_ack <= 1'b0;
         cnt <= 2'h0;
         mem_rdata <= ~mem_rdata;
      end else if (cnt >= dly) begin
         mem_ack <= 1'b1;
         cnt <= 2'h0;
         mem_rdata <= mem_cmd.bitmode ? {7'h2A, pat(mem_cmd.addr)} : cmd[mem_cmd.addr[7:0]];
         if (mem_cmd.we && mem_cmd.bitmode) begin
            wa_q.push_back(mem_cmd.addr);
            wd_q.push_back(mem_cmd.wdata[0]);
         end else if (mem_cmd.we) begin
            cmd[mem_cmd.addr[7:0]] = mem_cmd.wdata;
            n_bwr++;
         end
      end else begin
         cnt <= cnt + 2'h1;
         mem_rdata <= ~mem_rdata;
      end
   end
endmodule : sblt_mem_model
`default_nettype wire

// file: dv/tb_top.sv
// Self-checking bench of the scaled blit engine
`timescale 1ns/1ps
`default_nettype none
module tb_top import sblt_pkg::*; ;
   logic        clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
   logic        mem_req, mem_ack, busy;
   logic [7:0]  reg_addr = 8'h00, mem_rdata;
   logic [31:0] reg_wdata = 32'h0, reg_rdata, rdv;
   logic [1:0]  dly = 2'h0;
   sblt_mreq_t  mem_cmd;
   int          n_mismatch = 0, samples_checked = 0, seed = 79;
   always #4 clk = ~clk;
   sblt_engine dut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mem_req(mem_req),
      .mem_cmd(mem_cmd), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .busy(busy));
   sblt_mem_model mem (.clk(clk), .rst(rst), .dly(dly), .mem_req(mem_req), .mem_cmd(mem_cmd),
      .mem_ack(mem_ack), .mem_rdata(mem_rdata));
   task automatic conclude;
      $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
      if (n_mismatch == 0 && samples_checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : conclude
   task automatic cmp(input string nm, input logic [31:0] ex, input logic [31:0] got);
      samples_checked++;
      if (got !== ex) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", nm, ex, got);
      end
   endtask : cmp
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask : rd
   task automatic run(input int i);
      sblt_cmd_t   c, ce;
      logic [31:0] lp, eos, dp, dl, sl, sb, ea [$];
      logic        b2t, ed [$];
      logic [3:0]  bv;
      int          xf, yf, hx, vy, fl, e, k;
      c = {SBLT_OPCODE, 8'($random(seed)), 32'h1_0000 + 32'(i * 1024), 16'h0, 16'h0,
         32'h8000, 16'h30, 16'($random(seed))};
      c.hcode = i[3:0];
      if (i == 6) c.opcode = 8'h35;
      c.fw = 16'(1 + $unsigned($random(seed)) % 20);
      c.fh = i[1] ? 16'h4 : 16'(1 + $unsigned($random(seed)) % 5);
      b2t = i[0];
      dly <= 2'($random(seed));
      lp = 32'h100;
      dp = b2t ? 32'hFFFF_FFC0 : 32'h40;
      eos = i[1] ? c.dest + lp + 32'h80 + 32'(c.fw) - 32'h2 : 32'hFFFF_FFFF;
      for (k = 0; k < 18; k++) mem.cmd[8'h20 + k] = c[143 - 8 * k -: 8];
      wr(SBLT_REG_CMD_ADDR, 32'h20);
      wr(SBLT_REG_LP_OFS, lp);
      wr(SBLT_REG_EOS, eos);
      wr(SBLT_REG_DPITCH, dp);
      bv = 4'($random(seed));
      wr(SBLT_REG_BOOL, {28'h0, bv});
      rd(SBLT_REG_BOOL, rdv);
      cmp("bool reg", {28'h0, bv}, rdv);
      mem.n_bwr = 0;
      mem.wa_q.delete();
      mem.wd_q.delete();
      wr(SBLT_REG_CTRL, {30'h0, b2t, 1'b1});
      for (k = 0; k < 20000 && !(busy === 1'b0 && k > 2); k++) @(posedge clk);
      if (k == 20000) begin
         n_mismatch++;
         conclude();
      end
      xf = (c.hcode inside {0, 1, 2, 3, 5, 7, 11, 15}) ? c.hcode + 1 : 1;
      yf = c.vcode + 1;
      hx = (c.hclip < xf) ? c.hclip : 0;
      vy = (c.vclip < yf) ? c.vclip : 0;
      fl = -1;
      for (int l = 0; l < c.fh && fl < 0 && i != 6; l++) begin
         dl = b2t ? c.dest + lp - 32'(l) * dp : c.dest + lp + 32'(l) * dp;
         e = vy + l;
         sl = b2t ? c.src - 32'(e / yf) * c.pitch : c.src + 32'(e / yf) * c.pitch;
         if (dl + 32'(c.fw) - 32'h1 > eos) fl = l;
         else for (int x = 0; x < c.fw; x++) begin
            sb = sl + 32'((hx + x) / xf);
            ea.push_back(dl + 32'(x));
            ed.push_back(bv[{mem.pat(sb), mem.pat(dl + 32'(x))}]);
         end
      end
      ce = c;
      if (fl >= 0) begin
         ce.strip = b2t ? c.strip - 8'h1 : c.strip + 8'h1;
         ce.dest = dl - lp;
         ce.src = sl;
         ce.vclip = 4'(e % yf);
         ce.fh = c.fh - 16'(fl);
      end
      cmp("bytes written", (fl >= 0) ? 17 : 0, mem.n_bwr);
      for (k = 1; k < 18; k++) cmp("cmd byte", ce[143 - 8 * k -: 8], mem.cmd[8'h20 + k]);
      cmp("pixel count", ea.size(), mem.wa_q.size());
      for (k = 0; k < ea.size() && k < mem.wa_q.size(); k++) begin
         cmp("pixel addr", ea[k], mem.wa_q[k]);
         cmp("pixel value", ed[k], mem.wd_q[k]);
      end
      rd(SBLT_REG_STATUS, rdv);
      cmp("status", {28'h0, i == 6, fl >= 0, 2'b10}, rdv);
   endtask : run
   initial begin
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      for (int a = 0; a < 32; a += 4) begin
         rd(8'(a), rdv);
         cmp("reset reg", (a == 20) ? 32'hA : 32'h0, rdv);
      end
      wr(SBLT_REG_STATUS, 32'hF);
      rd(SBLT_REG_STATUS, rdv);
      cmp("status read only", 32'h0, rdv);
      for (int i = 0; i < 16; i++) run(i);
      conclude();
   end
endmodule : tb_top
`default_nettype wire

// file: hdl/sblt_combine.sv
// Two-operand Boolean pixel combiner
`timescale 1ns/1ps
`default_nettype none
module sblt_combine import sblt_pkg::*; (
   input  wire logic [3:0] code,
   input  wire logic       src,
   input  wire logic       dst,
   output logic            res
);
   // Truth table indexed by source and destination bit
   assign res = code[{src, dst}];

endmodule : sblt_combine
`default_nettype wire

// file: hdl/sblt_engine.sv
// Scaled blit to strip bitmap engine with register port and memory port
`timescale 1ns/1ps
`default_nettype none
//
// Contract
// - Opcode 0x36 then fixed parameter list
// - Expand source before combining with destination
// - Combine pixels by last Boolean code
// - Physical destination equals logical plus offset
// - Smaller frame transfers only that portion
// - Source line step uses command pitch only
// - Only listed horizontal codes scale
// - Skip left expanded bits by clip count
// - Vertical factor is code plus one
// - Skip top expanded lines by clip count
// - Reversed order clips from bottom edge
// - Fault when frame passes strip end
// - Fault rewrites strip number up or down
// - Fault rewrites addresses and vertical clip
// - Fault writes back remaining line count
module sblt_engine import sblt_pkg::*; (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic [7:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [31:0] reg_rdata,
   output logic             mem_req,
   output sblt_mreq_t       mem_cmd,
   input  wire logic        mem_ack,
   input  wire logic [7:0]  mem_rdata,
   output logic             busy
);
   sblt_state_t state_r;
   sblt_cmd_t   cmd_r;
   sblt_mreq_t  mreq_r;
   logic        req_r;
   logic [4:0]  idx_r;
   logic [15:0] line_r;
   logic [15:0] col_r;
   logic [4:0]  xsub_r;
   logic [4:0]  ysub_r;
   logic [31:0] sbit_r;
   logic [31:0] sline_r;
   logic [31:0] dlog_r;
   logic        src_bit_r;
   logic        b2t_r;
   logic [31:0] cmd_base_r;
   logic [31:0] lpofs_r;
   logic [31:0] eos_r;
   logic [31:0] dpitch_r;
   logic [3:0]  bool_r;
   logic        st_done_r;
   logic        st_fault_r;
   logic        st_badop_r;
   logic [31:0] rdata_r;

   wire logic [4:0]  fx;
   wire logic [4:0]  fy;
   wire logic        comb_bit;
   wire logic        start;
   wire logic [31:0] dline;
   wire logic [31:0] line_last;
   wire logic        frame_end;
   wire logic        fault_hit;
   wire logic        col_last;
   wire logic        x_wrap;
   wire logic        y_wrap;
   wire logic [4:0]  hclip_start;
   wire logic [4:0]  vclip_start;
   wire logic [31:0] dlog_step;
   wire logic [31:0] sline_step;
   wire logic [7:0]  strip_step;
   wire logic [7:0]  cur_byte;
   wire logic [31:0] status_word;

   // Byte of the parameter list at a given index
   function automatic logic [7:0] cmd_byte(input sblt_cmd_t c, input logic [4:0] i);
      logic [SBLT_CMD_BITS-1:0] flat;
      flat = c;
      return flat[(SBLT_CMD_BITS - 8) - 8 * int'(i) +: 8];
   endfunction : cmd_byte

   sblt_xfactor u_xfactor (
      .code   (cmd_r.hcode),
      .factor (fx)
   );

   sblt_combine u_combine (
      .code (bool_r),
      .src  (src_bit_r),
      .dst  (mem_rdata[0]),
      .res  (comb_bit)
   );

   assign fy          = {1'b0, cmd_r.vcode} + 5'h01;
   assign start       = reg_wr && (reg_addr == SBLT_REG_CTRL)
                     && reg_wdata[SBLT_CTRL_START] && (state_r == S_IDLE);
   assign dline       = dlog_r + lpofs_r;
   assign line_last   = dline + {16'h0000, cmd_r.fw} - 32'h0000_0001;
   assign frame_end   = (line_r == cmd_r.fh);
   assign fault_hit   = (line_last > eos_r);
   assign col_last    = ((col_r + 16'h0001) == cmd_r.fw);
   assign x_wrap      = ((xsub_r + 5'h01) == fx);
   assign y_wrap      = ((ysub_r + 5'h01) == fy);
   assign hclip_start = ({1'b0, cmd_r.hclip} < fx) ? {1'b0, cmd_r.hclip} : 5'h00;
   assign vclip_start = ({1'b0, cmd_r.vclip} < fy) ? {1'b0, cmd_r.vclip} : 5'h00;
   assign dlog_step   = b2t_r ? (dlog_r - dpitch_r) : (dlog_r + dpitch_r);
   // Reversed order walks upward, so clipping counts from the bottom
   assign sline_step  = b2t_r ? (sline_r - {16'h0000, cmd_r.pitch})
                              : (sline_r + {16'h0000, cmd_r.pitch});
   assign strip_step  = b2t_r ? (cmd_r.strip - 8'h01) : (cmd_r.strip + 8'h01);
   assign cur_byte    = cmd_byte(cmd_r, idx_r);
   assign status_word = {28'h0000000, st_badop_r, st_fault_r, st_done_r, busy};

   assign mem_req   = req_r;
   assign mem_cmd   = mreq_r;
   assign busy      = (state_r != S_IDLE);
   assign reg_rdata = rdata_r;

   // Register writes
   always_ff @(posedge clk) begin
      if (rst) begin
         b2t_r      <= 1'b0;
         cmd_base_r <= SBLT_RST_WORD;
         lpofs_r    <= SBLT_RST_WORD;
         eos_r      <= SBLT_RST_WORD;
         dpitch_r   <= SBLT_RST_WORD;
         bool_r     <= SBLT_RST_BOOL;
      end else if (reg_wr) begin
         unique case (reg_addr)
            SBLT_REG_CTRL: begin
               b2t_r <= reg_wdata[SBLT_CTRL_B2T];
            end
            SBLT_REG_CMD_ADDR: cmd_base_r <= reg_wdata;
            SBLT_REG_LP_OFS:   lpofs_r    <= reg_wdata;
            SBLT_REG_EOS:      eos_r      <= reg_wdata;
            SBLT_REG_DPITCH:   dpitch_r   <= reg_wdata;
            SBLT_REG_BOOL:     bool_r     <= reg_wdata[3:0];
            default: begin
            end
         endcase
      end
   end

   // Register reads, data one cycle after the strobe
   always_ff @(posedge clk) begin
      if (rst) begin
         rdata_r <= SBLT_RST_WORD;
      end else if (reg_rd) begin
         unique case (reg_addr)
            SBLT_REG_CTRL:     rdata_r <= {30'h0, b2t_r, 1'b0};
            SBLT_REG_CMD_ADDR: rdata_r <= cmd_base_r;
            SBLT_REG_LP_OFS:   rdata_r <= lpofs_r;
            SBLT_REG_EOS:      rdata_r <= eos_r;
            SBLT_REG_DPITCH:   rdata_r <= dpitch_r;
            SBLT_REG_BOOL:     rdata_r <= {28'h0000000, bool_r};
            SBLT_REG_STATUS:   rdata_r <= status_word;
            default:           rdata_r <= SBLT_RST_WORD;
         endcase
      end else begin
         rdata_r <= SBLT_RST_WORD;
      end
   end

   // Command engine
   always_ff @(posedge clk) begin
      if (rst) begin
         state_r    <= S_IDLE;
         cmd_r      <= '0;
         mreq_r     <= '0;
         req_r      <= 1'b0;
         idx_r      <= 5'h00;
         line_r     <= 16'h0000;
         col_r      <= 16'h0000;
         xsub_r     <= 5'h00;
         ysub_r     <= 5'h00;
         sbit_r     <= 32'h0000_0000;
         sline_r    <= 32'h0000_0000;
         dlog_r     <= 32'h0000_0000;
         src_bit_r  <= 1'b0;
         st_done_r  <= 1'b0;
         st_fault_r <= 1'b0;
         st_badop_r <= 1'b0;
      end else begin
         unique case (state_r)
            S_IDLE: begin
               if (start) begin
                  st_done_r  <= 1'b0;
                  st_fault_r <= 1'b0;
                  st_badop_r <= 1'b0;
                  idx_r      <= SBLT_IDX_FIRST;
                  state_r    <= S_FETCH;
               end
            end
            S_FETCH: begin
               if (!req_r) begin
                  req_r  <= 1'b1;
                  mreq_r <= '{we: 1'b0, bitmode: 1'b0,
                              addr: cmd_base_r + {27'h0, idx_r}, wdata: 8'h00};
               end else if (mem_ack) begin
                  req_r <= 1'b0;
                  cmd_r[(SBLT_CMD_BITS - 8) - 8 * int'(idx_r) +: 8] <= mem_rdata;
                  idx_r <= idx_r + 5'h01;
                  if (idx_r == SBLT_IDX_LAST) begin
                     state_r <= S_SETUP;
                  end
               end
            end
            S_SETUP: begin
               if (cmd_r.opcode != SBLT_OPCODE) begin
                  st_badop_r <= 1'b1;
                  state_r    <= S_DONE;
               end else begin
                  line_r  <= 16'h0000;
                  col_r   <= 16'h0000;
                  xsub_r  <= hclip_start;
                  ysub_r  <= vclip_start;
                  sbit_r  <= 32'h0000_0000;
                  sline_r <= cmd_r.src;
                  dlog_r  <= cmd_r.dest;
                  state_r <= S_LINE;
               end
            end
            S_LINE: begin
               if (frame_end || (cmd_r.fw == 16'h0000)) begin
                  state_r <= S_DONE;
               end else if (fault_hit) begin
                  cmd_r.strip <= strip_step;
                  cmd_r.dest  <= dlog_r;
                  cmd_r.src   <= sline_r;
                  cmd_r.vclip <= ysub_r[3:0];
                  cmd_r.fh    <= cmd_r.fh - line_r;
                  idx_r       <= SBLT_IDX_STRIP;
                  state_r     <= S_WBACK;
               end else begin
                  req_r   <= 1'b1;
                  mreq_r  <= '{we: 1'b0, bitmode: 1'b1,
                               addr: sline_r + sbit_r, wdata: 8'h00};
                  state_r <= S_RSRC;
               end
            end
            S_RSRC: begin
               if (mem_ack) begin
                  src_bit_r <= mem_rdata[0];
                  mreq_r    <= '{we: 1'b0, bitmode: 1'b1,
                                 addr: dline + {16'h0000, col_r}, wdata: 8'h00};
                  state_r   <= S_RDST;
               end
            end
            S_RDST: begin
               if (mem_ack) begin
                  mreq_r  <= '{we: 1'b1, bitmode: 1'b1,
                               addr: dline + {16'h0000, col_r},
                               wdata: {7'h00, comb_bit}};
                  state_r <= S_WDST;
               end
            end
            S_WDST: begin
               if (mem_ack) begin
                  req_r   <= 1'b0;
                  state_r <= S_LINE;
                  if (col_last) begin
                     col_r  <= 16'h0000;
                     xsub_r <= hclip_start;
                     sbit_r <= 32'h0000_0000;
                     line_r <= line_r + 16'h0001;
                     dlog_r <= dlog_step;
                     ysub_r <= y_wrap ? 5'h00 : (ysub_r + 5'h01);
                     if (y_wrap) begin
                        sline_r <= sline_step;
                     end
                  end else begin
                     col_r  <= col_r + 16'h0001;
                     xsub_r <= x_wrap ? 5'h00 : (xsub_r + 5'h01);
                     if (x_wrap) begin
                        sbit_r <= sbit_r + 32'h0000_0001;
                     end
                  end
               end
            end
            S_WBACK: begin
               if (!req_r) begin
                  req_r  <= 1'b1;
                  mreq_r <= '{we: 1'b1, bitmode: 1'b0,
                              addr: cmd_base_r + {27'h0, idx_r}, wdata: cur_byte};
               end else if (mem_ack) begin
                  req_r <= 1'b0;
                  idx_r <= idx_r + 5'h01;
                  if (idx_r == SBLT_IDX_LAST) begin
                     st_fault_r <= 1'b1;
                     state_r    <= S_DONE;
                  end
               end
            end
            S_DONE: begin
               st_done_r <= 1'b1;
               state_r   <= S_IDLE;
            end
            default: begin
               state_r <= S_IDLE;
               req_r   <= 1'b0;
            end
         endcase
      end
   end

endmodule : sblt_engine
`default_nettype wire

// file: hdl/sblt_pkg.sv
// Package: constants and types of the scaled blit to strip bitmap engine
package sblt_pkg;

   // Command byte layout, big-endian fields, byte 0 first
   localparam logic [7:0]  SBLT_OPCODE      = 8'h36;
   localparam int          SBLT_CMD_BYTES   = 18;
   localparam int          SBLT_CMD_BITS    = 8 * SBLT_CMD_BYTES;
   localparam logic [4:0]  SBLT_IDX_FIRST   = 5'h00;
   localparam logic [4:0]  SBLT_IDX_STRIP   = 5'h01;
   localparam logic [4:0]  SBLT_IDX_LAST    = 5'h11;

   // Register byte offsets
   localparam logic [7:0]  SBLT_REG_CTRL     = 8'h00;
   localparam logic [7:0]  SBLT_REG_CMD_ADDR = 8'h04;
   localparam logic [7:0]  SBLT_REG_LP_OFS   = 8'h08;
   localparam logic [7:0]  SBLT_REG_EOS      = 8'h0C;
   localparam logic [7:0]  SBLT_REG_DPITCH   = 8'h10;
   localparam logic [7:0]  SBLT_REG_BOOL     = 8'h14;
   localparam logic [7:0]  SBLT_REG_STATUS   = 8'h18;

   // Field positions
   localparam int          SBLT_CTRL_START   = 0;
   localparam int          SBLT_CTRL_B2T     = 1;
   localparam int          SBLT_ST_BUSY      = 0;
   localparam int          SBLT_ST_DONE      = 1;
   localparam int          SBLT_ST_FAULT     = 2;
   localparam int          SBLT_ST_BADOP     = 3;

   // Reset values
   localparam logic [31:0] SBLT_RST_WORD     = 32'h0000_0000;
   localparam logic [3:0]  SBLT_RST_BOOL     = 4'hA;

   typedef struct packed {
      logic [7:0]  opcode;
      logic [7:0]  strip;
      logic [31:0] dest;
      logic [15:0] fw;
      logic [15:0] fh;
      logic [31:0] src;
      logic [15:0] pitch;
      logic [3:0]  hclip;
      logic [3:0]  hcode;
      logic [3:0]  vclip;
      logic [3:0]  vcode;
   } sblt_cmd_t;

   typedef struct packed {
      logic        we;
      logic        bitmode;
      logic [31:0] addr;
      logic [7:0]  wdata;
   } sblt_mreq_t;

   typedef enum logic [8:0] {
      S_IDLE  = 9'h001,
      S_FETCH = 9'h002,
      S_SETUP = 9'h004,
      S_LINE  = 9'h008,
      S_RSRC  = 9'h010,
      S_RDST  = 9'h020,
      S_WDST  = 9'h040,
      S_WBACK = 9'h080,
      S_DONE  = 9'h100
   } sblt_state_t;

endpackage : sblt_pkg

// file: hdl/sblt_xfactor.sv
// Horizontal scale code to expansion factor decoder
`timescale 1ns/1ps
`default_nettype none
module sblt_xfactor import sblt_pkg::*; (
   input  wire logic [3:0] code,
   output logic      [4:0] factor
);
   wire logic supported;

   assign supported = (code == 4'h0) || (code == 4'h1) || (code == 4'h2) || (code == 4'h3)
                   || (code == 4'h5) || (code == 4'h7) || (code == 4'hB) || (code == 4'hF);
   // Unsupported codes fall back to no scaling
   assign factor = supported ? ({1'b0, code} + 5'h01) : 5'h01;

endmodule : sblt_xfactor
`default_nettype wire
